// File: pkg/smss_pkg.sv
package smss_pkg;

  // byte width and transmit queue depth
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  // last edge index of a byte (sixteen edges) and the pair of the 8th sample
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_PAIR = 3'h7;

  // width of the half-period gap counter used by the checks
  localparam int GAP_W = 12;

  //////////////////////////////////////////////////////////////////////////
  // configuration bits, held steady by software
  typedef struct packed {
    logic portEnableBit;
    logic masterMode;
    logic singleWireSelect;
    logic sharedPinOutputEnable;
    logic lowBitFirst;
    logic clockPolarity;
    logic clockPhase;
    logic [2:0] prescaleField;
    logic [2:0] rateSelectField;
  } smss_ctrl_t;

  // pin levels as seen at the pads
  typedef struct packed {
    logic shiftClk;
    logic mosi;
    logic miso;
    logic selectN;
  } smss_pin_in_t;

  // pad drive, enable high while this block drives the pin
  typedef struct packed {
    logic shiftClkOut;
    logic shiftClkOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
  } smss_pin_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_FINISH = 3'b100
  } smss_state_t;

  //////////////////////////////////////////////////////////////////////////
  // whole state of the port core
  typedef struct packed {
    smss_state_t fsm;
    logic [2:0] preCnt;
    logic [7:0] rateCnt;
    logic [3:0] edgeCnt;
    logic shiftClkLevel;
    logic [DATA_W-1:0] shifter;
    logic [DATA_W-1:0] txBuf;
    logic [DATA_W-1:0] rxBuf;
    logic outBit;
    logic txEmpty;
    logic rxFull;
    logic [2:0] clkSync;
    logic [2:0] mosiSync;
    logic [2:0] misoSync;
    logic [2:0] selSync;
    logic clkLvl;
    logic mosiLvl;
    logic misoLvl;
    logic selLvl;
    smss_pin_out_t pins;
  } smss_core_t;

  // after reset: idle, transmit buffer empty, select seen as high
  localparam smss_core_t CORE_RST = '{fsm: ST_IDLE, txEmpty: 1'b1,
    selSync: 3'h7, selLvl: 1'b1, default: '0};

endpackage

// File: hdl/smss_fifo.sv
`timescale 1ns/1ps
module smss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  import smss_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // depth must be a power of two so the pointers wrap by themselves
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic inReady;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } smss_fifo_st_t;

  smss_fifo_st_t st;
  smss_fifo_st_t next_st;
  logic push;
  logic pop;
  logic load;

  //////////////////////////////////////////////////////////////////////////
  // storage plus a registered head word
  always_comb begin
    next_st = st;
    push = inValid && st.inReady;
    pop = st.outValid && outReady;
    load = (!st.outValid || pop) && (st.count != '0);
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (load) begin
      next_st.outData = st.mem[st.rdPtr];
      next_st.rdPtr = st.rdPtr + 1'b1;
      next_st.outValid = 1'b1;
    end else if (pop) begin
      next_st.outValid = 1'b0;
    end
    next_st.count = st.count + CW'(push) - CW'(load);
    // ready is registered from the next count so the source sees full in the cycle the queue fills
    next_st.inReady = next_st.count != CW'(DEPTH);
    if (flush) begin
      next_st.wrPtr = '0;
      next_st.rdPtr = '0;
      next_st.count = '0;
      next_st.outValid = 1'b0;
      next_st.inReady = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{inReady: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign inReady = st.inReady;
  assign outValid = st.outValid;
  assign outData = st.outData;

endmodule

// File: hdl/smss_port.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - only a master starts a transfer; a slave waits for master clocks
// RULE_02 - master sends and captures bits in the same clock cycles
// RULE_03 - after a byte both shift registers hold each other's old byte
// RULE_04 - master drives the shift clock pin; slave takes it as input
// RULE_05 - partner holds select low; a deselected slave stays silent
// RULE_06 - written byte waits in transmit buffer until next transfer starts
// RULE_07 - finished byte is copied to a separate receive buffer
// RULE_08 - master: clock out, shifter to mosi, shifter input from miso
// RULE_09 - slave: clock from pin, shifter to miso, input from mosi
// RULE_10 - bit-rate generator runs from the bus clock only
// RULE_11 - prescale field divides bus clock by field value plus one
// RULE_12 - rate field further divides by two to the field plus one
// RULE_13 - with port disabled all four pins are released
// RULE_14 - master single-wire mode uses mosi as shared data pin
// RULE_15 - shared pin output enable bit sets shared pin direction
// RULE_16 - slave single-wire mode leaves mosi pin unused
// RULE_17 - slave single-wire uses miso as shared pin; master leaves it
// RULE_18 - disabling aborts transfer, empties buffers, clears full, sets empty
// RULE_19 - low-bit-first bit picks lsb-first, else msb-first
// RULE_20 - a byte is eight clock cycles; commit after eighth sample
module smss_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire smss_pkg::smss_ctrl_t ctrl,
  input wire logic dataWrValid,
  input wire logic [smss_pkg::DATA_W-1:0] dataWrByte,
  output logic dataWrReady,
  input wire logic dataRdStrobe,
  output logic [smss_pkg::DATA_W-1:0] shiftDataRegister,
  output logic receiveFullFlag,
  output logic transmitEmptyFlag,
  input wire smss_pkg::smss_pin_in_t pinIn,
  output smss_pkg::smss_pin_out_t pinOut
);
  import smss_pkg::*;

  smss_core_t st;
  smss_core_t next_st;
  logic fifoValid;
  logic [DATA_W-1:0] fifoData;
  logic fClk;
  logic fMosi;
  logic fMiso;
  logic fSel;
  logic selected;
  logic isMaster;
  logic serIn;
  logic clkEdge;
  logic preTick;
  logic halfTick;
  logic doLoad;
  logic doEdge;
  logic sampleEdge;
  logic commit;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // a new level counts only once the second and third stages agree
  function automatic logic filt(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  // bit leaving the shifter, end picked by the order bit
  function automatic logic outBitOf(input logic [DATA_W-1:0] sh,
                                    input logic lsbf);
    return lsbf ? sh[0] : sh[DATA_W-1];
  endfunction

  function automatic logic [DATA_W-1:0] shiftIn(
    input logic [DATA_W-1:0] sh, input logic b, input logic lsbf);
    return lsbf ? {b, sh[DATA_W-1:1]} : {sh[DATA_W-2:0], b};
  endfunction

  // half period in prescaled ticks is two to the field
  function automatic logic [7:0] rateLimit(input logic [2:0] r);
    return (8'h01 << r) - 8'h01;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // transmit queue in front of the transmit buffer
  smss_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) i_smss_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(!ctrl.portEnableBit),
    .inValid(dataWrValid),
    .inData(dataWrByte),
    .inReady(dataWrReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(st.txEmpty)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state of the port core
  always_comb begin
    next_st = st;
    // pad synchronisers, the first stage only feeds the second
    next_st.clkSync = {st.clkSync[1:0], pinIn.shiftClk};
    next_st.mosiSync = {st.mosiSync[1:0], pinIn.mosi};
    next_st.misoSync = {st.misoSync[1:0], pinIn.miso};
    next_st.selSync = {st.selSync[1:0], pinIn.selectN};
    fClk = filt(st.clkSync, st.clkLvl);
    fMosi = filt(st.mosiSync, st.mosiLvl);
    fMiso = filt(st.misoSync, st.misoLvl);
    fSel = filt(st.selSync, st.selLvl);
    next_st.clkLvl = fClk;
    next_st.mosiLvl = fMosi;
    next_st.misoLvl = fMiso;
    next_st.selLvl = fSel;
    isMaster = ctrl.masterMode;
    selected = !fSel; // RULE_05
    clkEdge = fClk != st.clkLvl; // RULE_09

    // input pin: miso for master, mosi for slave, swapped in single-wire
    serIn = (isMaster ^ ctrl.singleWireSelect) ? fMiso : fMosi; // RULE_08

    // bit-rate divider, counts bus clocks only outside ST_IDLE (while shifting or finishing)
    preTick = 1'b0;
    halfTick = 1'b0;
    if (st.fsm != ST_IDLE) begin // RULE_10
      if (st.preCnt == ctrl.prescaleField) begin // RULE_11
        next_st.preCnt = '0;
        preTick = 1'b1;
      end else begin
        next_st.preCnt = st.preCnt + 3'h1;
      end
      if (preTick) begin
        if (st.rateCnt == rateLimit(ctrl.rateSelectField)) begin // RULE_12
          next_st.rateCnt = '0;
          halfTick = 1'b1;
        end else begin
          next_st.rateCnt = st.rateCnt + 8'h01;
        end
      end
    end

    // software read clears the full flag; a commit below wins
    if (dataRdStrobe) begin
      next_st.rxFull = 1'b0;
    end

    // sequencer
    doLoad = 1'b0;
    doEdge = 1'b0;
    unique case (st.fsm)
      ST_IDLE: begin
        next_st.shiftClkLevel = ctrl.clockPolarity;
        next_st.preCnt = '0;
        next_st.rateCnt = '0;
        next_st.edgeCnt = '0;
        // slave never starts on its own, it waits to be selected
        doLoad = isMaster ? !st.txEmpty : selected; // RULE_01
        if (doLoad) begin
          next_st.fsm = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (isMaster) begin
          doEdge = halfTick;
        end else if (!selected) begin
          // deselect mid-byte drops the partial byte
          next_st.fsm = ST_IDLE; // RULE_05
        end else begin
          doEdge = clkEdge; // RULE_09
        end
        if (doEdge && st.edgeCnt == LAST_EDGE) begin // RULE_20
          next_st.fsm = isMaster ? ST_FINISH : ST_IDLE;
        end
      end
      ST_FINISH: begin
        // one idle half period between master bytes
        if (halfTick) begin
          next_st.fsm = ST_IDLE;
        end
      end
    endcase

    // queued byte enters the shifter at the start of a transfer
    if (doLoad) begin
      if (!st.txEmpty) begin
        next_st.shifter = st.txBuf; // RULE_06
        next_st.txEmpty = 1'b1;
      end
      next_st.outBit = outBitOf(next_st.shifter, ctrl.lowBitFirst); // RULE_19
    end

    // sample on one edge of each pair, drive on the other
    sampleEdge = st.edgeCnt[0] == ctrl.clockPhase;
    commit = 1'b0;
    if (doEdge) begin
      next_st.edgeCnt = st.edgeCnt + 4'h1;
      if (isMaster) begin
        next_st.shiftClkLevel = !st.shiftClkLevel; // RULE_04
      end
      if (sampleEdge) begin
        // shifting in while the old bits leave swaps the bytes
        next_st.shifter = shiftIn(st.shifter, serIn,
                                  ctrl.lowBitFirst); // RULE_02 RULE_03
        commit = st.edgeCnt[3:1] == LAST_PAIR; // RULE_20
      end else begin
        // drive on the opposite edge so the partner sees stable data
        next_st.outBit = outBitOf(st.shifter, ctrl.lowBitFirst); // RULE_19
      end
    end

    // an unread byte is kept; the new one is lost on overrun
    if (commit && (!st.rxFull || dataRdStrobe)) begin
      next_st.rxBuf = next_st.shifter; // RULE_07
      next_st.rxFull = 1'b1;
    end

    // refill the transmit buffer from the queue
    if (fifoValid && st.txEmpty) begin
      next_st.txBuf = fifoData; // RULE_06
      next_st.txEmpty = 1'b0;
    end

    // disable aborts everything and empties the buffers
    if (!ctrl.portEnableBit) begin
      next_st.fsm = ST_IDLE; // RULE_18
      next_st.txEmpty = 1'b1;
      next_st.rxFull = 1'b0;
      next_st.edgeCnt = '0;
      next_st.preCnt = '0;
      next_st.rateCnt = '0;
      next_st.shiftClkLevel = ctrl.clockPolarity;
    end

    // pin routing, all released while disabled
    next_st.pins = '0; // RULE_13
    if (ctrl.portEnableBit) begin
      if (isMaster) begin
        next_st.pins.shiftClkOut = next_st.shiftClkLevel; // RULE_04
        next_st.pins.shiftClkOe = 1'b1;
        next_st.pins.mosiOut = next_st.outBit; // RULE_08 RULE_14
        next_st.pins.mosiOe = ctrl.singleWireSelect ?
                              ctrl.sharedPinOutputEnable : 1'b1; // RULE_15
      end else begin
        // mosi is never driven by a slave, in single-wire it is unused
        next_st.pins.misoOut = next_st.outBit; // RULE_09 RULE_16
        next_st.pins.misoOe = selected &&
          (ctrl.singleWireSelect ?
           ctrl.sharedPinOutputEnable : 1'b1); // RULE_05 RULE_17
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign shiftDataRegister = st.rxBuf;
  assign receiveFullFlag = st.rxFull;
  assign transmitEmptyFlag = st.txEmpty;
  assign pinOut = st.pins;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // cycles since the last master clock toggle
  logic [GAP_W-1:0] gapCnt;
  logic [GAP_W-1:0] gapWant;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gapCnt <= '0;
    end else if (next_st.shiftClkLevel != st.shiftClkLevel) begin
      gapCnt <= '0;
    end else begin
      gapCnt <= gapCnt + 12'h001;
    end
  end
  assign gapWant = ({9'h000, ctrl.prescaleField} + 12'h001)
                   << ctrl.rateSelectField;

  slave_no_start_a: assert property ( // RULE_01
    (ctrl.portEnableBit && !ctrl.masterMode && st.fsm == ST_IDLE &&
     st.selSync[2:1] == 2'b11 && st.selLvl) |=> st.fsm == ST_IDLE)
    else $error("slave left idle while deselected");

  half_period_a: assert property ( // RULE_11
    (ctrl.portEnableBit && ctrl.masterMode && st.fsm == ST_SHIFT &&
     doEdge && st.edgeCnt != 4'h0) |-> gapCnt + 12'h001 == gapWant)
    else $error("master half period differs from divider setting");

  commit_eighth_a: assert property ( // RULE_20
    (ctrl.portEnableBit && $rose(st.rxFull))
      |-> $past(st.edgeCnt[3:1]) == LAST_PAIR)
    else $error("receive buffer filled before the eighth sample");

  rx_copy_a: assert property ( // RULE_07
    $rose(st.rxFull) |-> st.rxBuf == st.shifter)
    else $error("receive buffer differs from shifter at commit");

  tx_load_a: assert property ( // RULE_06
    ($past(st.fsm) == ST_IDLE && st.fsm == ST_SHIFT && !$past(st.txEmpty))
      |-> st.shifter == $past(st.txBuf) && st.txEmpty)
    else $error("shifter not loaded from transmit buffer at start");

  clk_drive_a: assert property ( // RULE_04
    (ctrl.portEnableBit && ctrl.masterMode)
      |=> st.pins.shiftClkOe && !st.pins.misoOe)
    else $error("master does not drive the shift clock");

  pins_off_a: assert property ( // RULE_13
    !ctrl.portEnableBit |=> st.pins == '0)
    else $error("pins driven while port disabled");

  disable_clear_a: assert property ( // RULE_18
    !ctrl.portEnableBit
      |=> st.txEmpty && !st.rxFull && st.fsm == ST_IDLE)
    else $error("disable did not clear buffers and state");

  shared_dir_a: assert property ( // RULE_15
    (ctrl.portEnableBit && ctrl.masterMode && ctrl.singleWireSelect)
      |=> st.pins.mosiOe == $past(ctrl.sharedPinOutputEnable))
    else $error("shared pin direction does not follow enable bit");

  slave_mosi_a: assert property ( // RULE_16
    (ctrl.portEnableBit && !ctrl.masterMode)
      |=> !st.pins.mosiOe && !st.pins.shiftClkOe)
    else $error("slave drives mosi or the shift clock");

  slave_quiet_a: assert property ( // RULE_05
    (ctrl.portEnableBit && !ctrl.masterMode &&
     st.selSync[2:1] == 2'b11 && st.selLvl) |=> !st.pins.misoOe)
    else $error("deselected slave drives miso");

endmodule

// File: tb/smss_far_end.sv
`timescale 1ns/1ps
// far end of the serial link, mode 0 only (clock idles low, sample rising)
module smss_far_end #(
  parameter logic [7:0] SEED = 8'hA5
) (
  input wire logic clk,
  input wire logic en,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  output logic farClk,
  output logic farMosi,
  output logic farMiso,
  output logic farSelN,
  output logic [7:0] rxByte
);
  logic [7:0] sh;
  logic [3:0] n;
  logic hold;
  event rxDone;

  // lines idle, select high, clock still
  initial begin
    farClk = 1'b0;
    farMosi = 1'b0;
    farSelN = 1'b1;
  end
  assign farMiso = sh[7];

  //////////////////////////////////////////////////////////////////////////
  // slave role: capture on rising, answer with the inverse of each byte
  always @(posedge sclk or negedge en) begin
    if (!en) begin
      n = 4'h0;
      sh = SEED;
      hold = 1'b0;
    end else begin
      rxByte = {rxByte[6:0], mosi};
      n = n + 4'h1;
      if (n == 4'h8) begin
        n = 4'h0;
        sh = ~rxByte;
        hold = 1'b1;
        -> rxDone;
      end
    end
  end

  // shift on falling; a fresh byte keeps its first bit in place
  always @(negedge sclk) begin
    // a disabled model keeps its seed byte for the next enable
    if (hold || !en) begin
      hold = 1'b0;
    end else begin
      sh = {sh[6:0], ~sh[7]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // master role: one frame, half period 8 cycles, clock still between
  task automatic runMaster(input logic [7:0] tx, input logic sel,
    output logic [7:0] rx);
    farSelN = !sel;
    farMosi = tx[7];
    repeat (8) @(negedge clk);
    for (int i = 6; i >= -1; i--) begin
      farClk = 1'b1;
      rx = {rx[6:0], miso};
      repeat (8) @(negedge clk);
      farClk = 1'b0;
      if (i >= 0) begin
        farMosi = tx[i];
      end else begin
        // select ends with the last clock edge: a select held past it
        // would let the port reload a byte for a frame that never comes
        farSelN = 1'b1;
        farMosi = ~farMosi; // a released line must not keep its last bit
      end
      repeat (8) @(negedge clk);
    end
  endtask
endmodule

// File: tb/test_spi_master_slave_shift_port.sv
`timescale 1ns/1ps
module test_spi_master_slave_shift_port;
  import smss_pkg::*;
  localparam logic [7:0] FAR_SEED = 8'hA5;
  logic clk, sys_rst, dataWrValid, dataWrReady, dataRdStrobe;
  logic receiveFullFlag, transmitEmptyFlag, farEn, lastClk, prevFull;
  logic farClk, farMosi, farMiso, farSelN;
  logic [7:0] dataWrByte, shiftDataRegister, farNext, farRx;
  smss_ctrl_t ctrl;
  smss_pin_in_t pinIn;
  smss_pin_out_t pinOut;
  logic [7:0] expDut[$];
  logic [7:0] expFar[$];
  logic [7:0] sentQ[$];
  int fail_count, n_compared, expH, gap, togg, n;

  smss_port i_smss_port (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl),
    .dataWrValid(dataWrValid), .dataWrByte(dataWrByte),
    .dataWrReady(dataWrReady), .dataRdStrobe(dataRdStrobe),
    .shiftDataRegister(shiftDataRegister),
    .receiveFullFlag(receiveFullFlag),
    .transmitEmptyFlag(transmitEmptyFlag), .pinIn(pinIn), .pinOut(pinOut));
  smss_far_end #(.SEED(FAR_SEED)) i_smss_far_end (.clk(clk), .en(farEn),
    .sclk(pinIn.shiftClk), .mosi(pinIn.mosi), .miso(pinIn.miso),
    .farClk(farClk), .farMosi(farMosi), .farMiso(farMiso),
    .farSelN(farSelN), .rxByte());

  // wire levels worked out from the port's enables, far end drives otherwise
  assign pinIn = '{shiftClk: pinOut.shiftClkOe ? pinOut.shiftClkOut : farClk,
    mosi: pinOut.mosiOe ? pinOut.mosiOut : farMosi,
    miso: pinOut.misoOe ? pinOut.misoOut : farMiso, selectN: farSelN};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
  endfunction

  // disable first so every mode starts from a soft reset
  task automatic setCtrl(input logic m, sw, oe, lbf, input logic [2:0] p, r);
    ctrl.portEnableBit = 1'b0;
    farEn = 1'b0;
    repeat (2) @(negedge clk);
    ctrl = '{1'b1, m, sw, oe, lbf, 1'b0, 1'b0, p, r};
    farEn = m && !sw;
    farNext = FAR_SEED;
    expH = (int'(p) + 1) << r;
    repeat (2) @(negedge clk);
  endtask

  // queue one byte and note what both ends should receive
  task automatic send(input logic [7:0] d);
    logic [7:0] pr;
    for (int k = 0; dataWrReady !== 1'b1; k++) begin
      if (k > 100) begin
        check(16'h0, 16'h1);
        results();
      end
      @(negedge clk);
    end
    dataWrByte = d;
    dataWrValid = 1'b1;
    @(negedge clk);
    dataWrValid = 1'b0;
    // let an edge pass so a following call never rewrites valid at once
    @(negedge clk);
    pr = ctrl.lowBitFirst ? rev(d) : d;
    expFar.push_back(pr);
    expDut.push_back(ctrl.lowBitFirst ? rev(farNext) : farNext);
    farNext = ~pr;
  endtask

  task automatic drain(input int bound);
    for (int k = 0; expDut.size() + expFar.size() > 0; k++) begin
      if (k > bound) begin
        check(16'h0, 16'h1);
        results();
      end
      @(negedge clk);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // read the receive buffer as soon as it fills, so no byte is dropped
  always @(negedge clk) dataRdStrobe <= receiveFullFlag;

  // result watcher: each new receive byte retires the oldest note
  always @(negedge clk) begin
    if (receiveFullFlag === 1'b1 && prevFull !== 1'b1) begin
      if (expDut.size() == 0) check(16'h0, 16'h1);
      else check(16'(shiftDataRegister), 16'(expDut.pop_front()));
    end
    prevFull = receiveFullFlag;
  end

  // far-end watcher: bytes seen on the wire by the partner
  always @(i_smss_far_end.rxDone) begin
    if (expFar.size() == 0) check(16'h0, 16'h1);
    else check(16'(i_smss_far_end.rxByte), 16'(expFar.pop_front()));
  end

  // bit-rate watcher: spacing of clock toggles inside one byte
  always @(negedge clk) begin
    gap++;
    if (ctrl.portEnableBit !== 1'b1) togg = 0;
    else if (ctrl.masterMode && pinOut.shiftClkOut !== lastClk) begin
      if (togg % 16 != 0) check(16'(gap), 16'(expH));
      togg++;
      gap = 0;
    end
    lastClk = pinOut.shiftClkOut;
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h902d));
    ctrl = '0;
    dataWrValid = 1'b0;
    dataWrByte = 8'h00;
    farEn = 1'b0;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    check(16'({dataWrReady, transmitEmptyFlag, receiveFullFlag}),
          16'h6);
    check(16'({shiftDataRegister, pinOut}), 16'h0);
    $display("reset test done");
    // pin ownership for every mode with the port idle
    for (int k = 0; k < 8; k++) begin
      setCtrl(k[2], k[1], k[0], 1'b0, 3'h0, 3'h0);
      check(16'(pinOut.shiftClkOe), 16'(k[2]));
      check(16'(pinOut.mosiOe), 16'(k[2] & (!k[1] | k[0])));
      check(16'(pinOut.misoOe), 16'h0);
      // idle clock level follows the polarity bit, driven only by a master
      ctrl.clockPolarity = 1'b1;
      repeat (2) @(negedge clk);
      check(16'(pinOut.shiftClkOut), 16'(k[2]));
    end
    $display("pin mode test done");
    // master exchanges over every prescale and rate code, both orders
    for (int c = 0; c < 8; c++) begin
      setCtrl(1'b1, 1'b0, 1'b0, c[0], 3'(c), 3'(7 - c));
      repeat (2) send(8'($urandom));
      drain(9000);
      repeat (2 * expH + 4) @(negedge clk);
      check(16'(togg), 16'd32);
    end
    $display("master rate test done");
    // abort in mid-byte with more bytes queued behind it
    setCtrl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7, 3'h3);
    repeat (3) send(8'($urandom));
    repeat (300) @(negedge clk);
    ctrl.portEnableBit = 1'b0;
    farEn = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({transmitEmptyFlag, receiveFullFlag}), 16'h2);
    check(16'({pinOut.shiftClkOe, pinOut.mosiOe, pinOut.misoOe}),
          16'h0);
    expDut.delete();
    expFar.delete();
    ctrl.portEnableBit = 1'b1;
    repeat (400) @(negedge clk);
    check(16'({togg[7:0], transmitEmptyFlag}), 16'h1);
    $display("abort test done");
    // slave: clocks while deselected, fill queue, then drain frame by frame
    setCtrl(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    i_smss_far_end.runMaster(8'h3C, 1'b0, farRx);
    for (n = 0; n < 40 && dataWrReady === 1'b1; n++) begin
      dataWrByte = 8'($urandom);
      dataWrValid = 1'b1;
      sentQ.push_back(dataWrByte);
      @(negedge clk);
    end
    dataWrValid = 1'b0;
    check(16'(n >= 16 && n < 40), 16'h1);
    while (sentQ.size() > 0) begin
      farNext = 8'($urandom);
      expDut.push_back(farNext);
      i_smss_far_end.runMaster(farNext, 1'b1, farRx);
      check(16'(farRx), 16'(sentQ.pop_front()));
    end
    drain(200);
    check(16'(transmitEmptyFlag), 16'h1);
    $display("slave queue test done");
    results();
  end
endmodule
